// [verification/peripheral_signal_routing_test.sv]
// Purpose: Self-checking bench for peripheral_signal_routing
// Assumes: Register model below mirrors masks and write locks
// Notes:   Bus answers are awaited, never counted
module peripheral_signal_routing_test;
  timeunit 1ns;
  timeprecision 1ps;
  import routing_pkg::*;
  logic clk_sys = 0, rstn = 0, read = 0, write = 0, specialMode = 0, irqPinN = 1, irqServiced = 0;
  logic comparatorOut = 0, serialTx0 = 0, serialRx1 = 0, transceiverRxd = 1, directTxBit = 0;
  logic transceiverEnable = 0, pinAd5 = 0, pinE0 = 0, auxClock = 0;
  logic waitrequest, serialRx0, transceiverTxd, adcTrigger, busClockOutPin, busClockOutOe, irqRequest;
  logic [ADDR_W-1:0]    address = '0;
  logic [DATA_W-1:0]    writedata = '0, readdata, q;
  logic [7:0]           pwmOut = '0, m [16] = '{default: 8'h00};
  logic [5:2]           tmr0Out = '0, tmr0Oe = '0, tmr0CapIn;
  logic [1:0]           tmr1Out = '0, tmr1Oe = '0, tmr1CapIn;
  logic [NUM_LINES-1:0] pinIn, gpioOut = '0, gpioDir = '0, pullEnable = '0, pinOut, pinOe, pinState, pullActive;
  logic [7:0]           mk [16] = '{MASK_SERIAL, MASK_PWM, MASK_TIMER, MASK_TRIG, MASK_CAP, MASK_CLOCK, MASK_IRQ,
                                    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
  bit                   lk [16];
  int                   failures = 0, n_tests = 0;
  int                   pa [8] = '{9, 1, 8, 3, 16, 20, 17, 21};
  logic [NUM_LINES-1:0] pinPrev;

  peripheral_signal_routing peripheral_signal_routing_inst (.byteenable(4'hF), .*);
  routing_partner routing_partner_inst (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

  always #2.5 clk_sys = ~clk_sys;
  // Pin levels one edge back, what the input copy must show
  always @(posedge clk_sys) pinPrev <= pinIn;

  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(bit w, int i, logic [7:0] d);
    @(posedge clk_sys);
    address <= ADDR_W'(i * 4);
    read <= !w;
    write <= w;
    writedata <= {24'h000000, d};
    @(posedge clk_sys iff waitrequest === 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // Write plus model update; locks only bite outside special mode
  task automatic wr(int i, logic [7:0] d);
    int k;
    k = i - 'h200;
    bus(1, i, d);
    if (k > 12 && !specialMode) d = m[k];
    if (lk[k] && !specialMode) d = (k == 6) ? {m[6][7], d[6:0]} : m[k];
    if (k inside {1, 2, 3, 6} && !specialMode) lk[k] = 1'b1;
    m[k] = d & mk[k];
  endtask : wr
  task automatic rd(int i);
    bus(0, i, 8'h00);
    chk("readdata", {24'h000000, m[i - 'h200]}, q);
  endtask : rd
  task automatic test_done;
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    void'($urandom(88));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    tick(4);
    for (int s = 0; s < 2; s++) begin
      specialMode <= s[0];
      for (int i = 'h200; i < 'h210; i++) begin
        rd(i);
        wr(i, 8'($urandom));
        wr(i, 8'($urandom));
        rd(i);
      end
    end
    wr('h200, 8'h00);
    for (int n = 0; n < 16; n++) begin
      wr('h201, 8'($urandom));
      wr('h202, n[0] ? 8'($urandom) : 8'h00);
      wr('h205, 8'($urandom));
      {pwmOut, tmr0Out, tmr1Out} <= 14'($urandom);
      {gpioOut, gpioDir, pullEnable} <= 66'({$urandom, $urandom, $urandom});
      {serialTx0, serialRx1, transceiverRxd, directTxBit, transceiverEnable, pinAd5, pinE0, auxClock} <= 8'($urandom);
      tmr0Oe <= {4{n[0]}};
      tmr1Oe <= {2{n[0]}};
      tick(3);
      chk("busClockOutOe", !m[5][7], busClockOutOe);
      chk("pullActive", pullEnable & ~pinOe, pullActive);
      chk("pinState", pinPrev, pinState);
      chk("serialRx0", transceiverRxd, serialRx0);
      chk("transceiverTxd", serialTx0, transceiverTxd);
      for (int c = 0; c < 8; c++) if (!n[0] && c != 1 && c != 3) chk("pwm", pwmOut[c], pinOut[m[1][c] ? pa[c] : c]);
      for (int c = 2; c < 6; c++) if (n[0]) chk("tmr0", tmr0Out[c], pinOut[m[2][c] ? 14 + c : 8 + c]);
      for (int c = 2; c < 6; c++) if (n[0] && (c != 3 || m[4][1:0] == 2'h0)) chk("cap0", tmr0Out[c], tmr0CapIn[c]);
      for (int c = 0; c < 2; c++) if (n[0]) chk("cap1", tmr1Out[c], tmr1CapIn[c]);
      for (int c = 0; c < 2; c++) if (n[0]) chk("tmr1", tmr1Out[c], pinOut[c ? (m[2][7] ? 1 : 15) : (m[2][6] ? 7 : 14)]);
    end
    // Serial routes with timers parked; open route with transceiver off frees T0
    wr('h202, 8'h00);
    wr('h200, 8'h01);
    tick(3);
    chk("transceiverTxd", directTxBit, transceiverTxd);
    transceiverEnable <= 1'b0;
    wr('h200, 8'h06);
    tick(3);
    chk("openS1", {1'b1, serialTx0}, {pinOe[LINE_S + 1], pinOut[LINE_S + 1]});
    chk("freedT0", m[1][2] | gpioDir[LINE_T], pinOe[LINE_T]);
    #1 chk("busClockOutPin", 1, busClockOutPin);
    tick(1);
    // Comparator source rising then falling, then a plain analog pin source
    for (int v = 0; v < 3; v++) begin
      {pinAd5, comparatorOut} <= {2{v[0]}};
      wr('h203, (v == 2) ? 8'h02 : (v == 1) ? 8'h0C : 8'h08);
      tick(3);
      {pinAd5, comparatorOut} <= {2{!v[0]}};
      tick(2);
      chk("adcTrigger", 1, adcTrigger);
      tick(1);
      chk("adcTrigger", 0, adcTrigger);
    end
    // Level mode, then a latched falling edge cleared by service
    wr('h206, 8'h40);
    irqPinN <= 1'b0;
    tick(2);
    chk("irqRequest", 1, irqRequest);
    irqPinN <= 1'b1;
    wr('h206, 8'hC0);
    irqPinN <= 1'b0;
    tick(1);
    irqPinN <= 1'b1;
    tick(3);
    chk("irqRequest", 1, irqRequest);
    irqServiced <= 1'b1;
    tick(1);
    irqServiced <= 1'b0;
    tick(2);
    chk("irqRequest", 0, irqRequest);
    test_done;
  end

  // Watchdog, far beyond the several hundred cycles the run needs
  initial begin
    #100000;
    failures++;
    test_done;
  end
endmodule : peripheral_signal_routing_test

// [verification/routing_partner.sv]
// Purpose: Package-line model that closes the driven lines back onto pinIn
// Assumes: No pull devices on the board side
// Notes:   A released line never keeps its last value, it flips every cycle
module routing_partner (
  input  wire logic                              clk_sys,
  input  wire logic [routing_pkg::NUM_LINES-1:0] pinOut,
  input  wire logic [routing_pkg::NUM_LINES-1:0] pinOe,
  output logic      [routing_pkg::NUM_LINES-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  import routing_pkg::*;
  logic [NUM_LINES-1:0] floatPat = '0;
  // Floating level changes every cycle, so stale data cannot pass as good
  always @(posedge clk_sys) begin
    floatPat <= ~floatPat;
  end
  // Driven lines show their drive, the rest float
  assign pinIn = (pinOe & pinOut) | (~pinOe & floatPat);
endmodule : routing_partner

// [verilog/peripheral_signal_routing.sv]
// Purpose: Routing of peripheral channels to package lines with Avalon-MM registers
// Assumes: All peripheral and pin inputs are synchronous to clk_sys
// Notes:   Answers every access two edges after it appears; pin outputs are registered
// Contract
// R1: Routing registers write once unless special mode; serial and capture route registers stay writable anytime
// R2: PWM 5,4,2,0 to alternate or P line
// R3: PWM 7 to J1/P7, 6 to S1/P6
// R4: Timer1 channels 1,0 to P1/T7, P7/T6
// R5: Timer0 channels 5..2 to S3..S0 or own T
// R6: Comparator bit overrides trigger source field
// R7: Polarity bit selects falling or rising edge
// R8: Trigger field picks P6, AD5, E0, timer OC2
// R9: Capture3 field picks aux clock, rx1, rx0, pin
// R10: Clock disable bit gates bus-rate clock output
// R11: Edge mode latches falling edges, else level
// R12: Edge bit write-once, connect bit anytime
// R13: Connect bit attaches interrupt pin to logic
// R14: Factory test registers writable only special mode
// R15: Reserved bits ignore writes, read zero
// R16: Settings accepted anytime, may stay inactive
// R17: GPIO only on free lines; input always pin
// R18: Pull control independent of function priority
// R19: Open route, transceiver off frees T0/T1
// R20: Serial route field selects four connections
// R21: Reads synchronous; writes anytime unless restricted
// R22: Lock flag per write-once register until reset
// R23: Polarity inversion before edge detection
module peripheral_signal_routing (
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic [routing_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [routing_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                  byteenable,
  output logic      [routing_pkg::DATA_W-1:0] readdata,
  output logic                             waitrequest,
  input  wire logic                        specialMode,
  input  wire logic [7:0]                  pwmOut,
  input  wire logic [5:2]                  tmr0Out,
  input  wire logic [5:2]                  tmr0Oe,
  input  wire logic [1:0]                  tmr1Out,
  input  wire logic [1:0]                  tmr1Oe,
  output logic      [5:2]                  tmr0CapIn,
  output logic      [1:0]                  tmr1CapIn,
  input  wire logic [routing_pkg::NUM_LINES-1:0] pinIn,
  input  wire logic [routing_pkg::NUM_LINES-1:0] gpioOut,
  input  wire logic [routing_pkg::NUM_LINES-1:0] gpioDir,
  input  wire logic [routing_pkg::NUM_LINES-1:0] pullEnable,
  output logic      [routing_pkg::NUM_LINES-1:0] pinOut,
  output logic      [routing_pkg::NUM_LINES-1:0] pinOe,
  output logic      [routing_pkg::NUM_LINES-1:0] pinState,
  output logic      [routing_pkg::NUM_LINES-1:0] pullActive,
  input  wire logic                        serialTx0,
  output logic                             serialRx0,
  input  wire logic                        serialRx1,
  input  wire logic                        transceiverRxd,
  output logic                             transceiverTxd,
  input  wire logic                        directTxBit,
  input  wire logic                        transceiverEnable,
  input  wire logic                        comparatorOut,
  input  wire logic                        pinAd5,
  input  wire logic                        pinE0,
  input  wire logic                        auxClock,
  output logic                             adcTrigger,
  output logic                             busClockOutPin,
  output logic                             busClockOutOe,
  input  wire logic                        irqPinN,
  input  wire logic                        irqServiced,
  output logic                             irqRequest
);
  import routing_pkg::*;

  typedef struct packed {
    bus_phase_type          phase;
    logic [7:0]             rdata;
    logic [2:0]             serialRoute;
    logic [7:0]             pwmRoute;
    logic [7:0]             timerRoute;
    logic [3:0]             trigRoute;
    logic [1:0]             capRoute;
    logic                   clkOutDisable;
    logic                   irqEdge;
    logic                   irqConnect;
    logic [7:0]             factA;
    logic [7:0]             factB;
    logic [7:0]             factC;
    logic                   pwmLock;
    logic                   timerLock;
    logic                   trigLock;
    logic                   irqLock;
    logic                   irqPrev;
    logic                   irqLatch;
    logic                   irqReq;
    logic [NUM_LINES-1:0]   pinOut;
    logic [NUM_LINES-1:0]   pinOe;
    logic [NUM_LINES-1:0]   pinState;
    logic [NUM_LINES-1:0]   pullActive;
    logic [5:2]             cap0;
    logic [1:0]             cap1;
    logic                   serRx0;
    logic                   lnTx;
  } state_type;

  state_type  state_ff;
  state_type  nxt_state;
  logic       rstSyncN;
  logic       wrTake;
  logic [9:0] regIdx;
  logic       trigLevel;

  // Reset release through two flip-flops
  reset_sync u_reset_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .rstSyncN (rstSyncN)
  );

  // Readback of one register word, unmapped and reserved bits as zero
  function automatic logic [7:0] readValue(input logic [9:0] idx, input state_type s);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_SERIAL_ROUTE) begin
      v = {5'h00, s.serialRoute};
    end else if (idx == IDX_PWM_ROUTE) begin
      v = s.pwmRoute & MASK_PWM; // R15
    end else if (idx == IDX_TIMER_ROUTE) begin
      v = s.timerRoute & MASK_TIMER;
    end else if (idx == IDX_TRIG_ROUTE) begin
      v = {4'h0, s.trigRoute};
    end else if (idx == IDX_CAP_ROUTE) begin
      v = {6'h00, s.capRoute};
    end else if (idx == IDX_CLOCK_CTRL) begin
      v = {s.clkOutDisable, 7'h00};
    end else if (idx == IDX_IRQ_CTRL) begin
      v = {s.irqEdge, s.irqConnect, 6'h00};
    end else if (idx == IDX_FACTORY_A) begin
      v = s.factA;
    end else if (idx == IDX_FACTORY_B) begin
      v = s.factB;
    end else if (idx == IDX_FACTORY_C) begin
      v = s.factC;
    end
    return v;
  endfunction : readValue

  // Word index of the byte address; low two bits ignored
  assign regIdx = address[ADDR_W-1:2];

  // Bus handshake: first edge latches read data, second edge completes
  assign waitrequest = (read | write) & (state_ff.phase != BUS_ANSWER); // R21
  assign wrTake      = write & (state_ff.phase == BUS_ANSWER) & byteenable[0];

  // Trigger source selection ahead of the edge detector
  always_comb begin
    if (state_ff.trigRoute[TRIG_CMP_BIT]) begin
      trigLevel = comparatorOut; // R6
    end else begin
      case (state_ff.trigRoute[1:0]) // R8
        TRIG_PIN_P6: trigLevel = pinIn[LINE_P + 6];
        TRIG_AD5:    trigLevel = pinAd5;
        TRIG_PIN_E0: trigLevel = pinE0;
        default:     trigLevel = tmr0Out[2];
      endcase
    end
  end

  trigger_edge u_trigger_edge (
    .clk_sys   (clk_sys),
    .rstSyncN  (rstSyncN),
    .level     (trigLevel),
    .invert    (state_ff.trigRoute[TRIG_INV_BIT]),
    .trigPulse (adcTrigger)
  );

  // Register writes, routing, interrupt pin handling
  always_comb begin
    logic [NUM_LINES-1:0] own;
    logic [NUM_LINES-1:0] drv;
    logic [NUM_LINES-1:0] fdat;
    logic [4:0]           l;
    logic [7:0]           wd;
    logic                 fall;
    own       = '0;
    drv       = '0;
    fdat      = '0;
    l         = 5'h00;
    wd        = writedata[7:0];
    fall      = 1'b0;
    nxt_state = state_ff;

    // Bus phase; a request is answered one cycle after it is seen
    nxt_state.phase = ((read | write) && state_ff.phase == BUS_IDLE) ? BUS_ANSWER : BUS_IDLE;
    if (read && state_ff.phase == BUS_IDLE) begin
      nxt_state.rdata = readValue(regIdx, state_ff); // R21
    end

    // Register writes; reserved bits are masked off before storing
    if (wrTake) begin
      if (regIdx == IDX_SERIAL_ROUTE) begin
        nxt_state.serialRoute = wd[2:0]; // R16
      end else if (regIdx == IDX_PWM_ROUTE && (specialMode || !state_ff.pwmLock)) begin
        nxt_state.pwmRoute = wd & MASK_PWM; // R1 R15
        nxt_state.pwmLock  = state_ff.pwmLock | ~specialMode; // R22
      end else if (regIdx == IDX_TIMER_ROUTE && (specialMode || !state_ff.timerLock)) begin
        nxt_state.timerRoute = wd & MASK_TIMER; // R1
        nxt_state.timerLock  = state_ff.timerLock | ~specialMode; // R22
      end else if (regIdx == IDX_TRIG_ROUTE && (specialMode || !state_ff.trigLock)) begin
        nxt_state.trigRoute = wd[3:0]; // R1
        nxt_state.trigLock  = state_ff.trigLock | ~specialMode; // R22
      end else if (regIdx == IDX_CAP_ROUTE) begin
        nxt_state.capRoute = wd[1:0];
      end else if (regIdx == IDX_CLOCK_CTRL) begin
        nxt_state.clkOutDisable = wd[CLK_DIS_BIT];
      end else if (regIdx == IDX_IRQ_CTRL) begin
        nxt_state.irqConnect = wd[IRQ_CONN_BIT]; // R12
        if (specialMode || !state_ff.irqLock) begin
          nxt_state.irqEdge = wd[IRQ_EDGE_BIT]; // R12
          nxt_state.irqLock = state_ff.irqLock | ~specialMode; // R22
        end
      end else if (specialMode) begin
        if (regIdx == IDX_FACTORY_A) begin
          nxt_state.factA = wd; // R14
        end else if (regIdx == IDX_FACTORY_B) begin
          nxt_state.factB = wd; // R14
        end else if (regIdx == IDX_FACTORY_C) begin
          nxt_state.factC = wd; // R14
        end
      end
    end

    // PWM channels, lowest priority among the functions
    for (int ch = 0; ch < 8; ch++) begin
      if (MASK_PWM[ch]) begin
        l       = lineOf(FN_PWM, ch, state_ff.pwmRoute[ch]); // R2 R3
        own[l]  = 1'b1;
        drv[l]  = 1'b1;
        fdat[l] = pwmOut[ch];
      end
    end

    // Serial and transceiver connections
    nxt_state.serRx0 = transceiverRxd;
    nxt_state.lnTx   = serialTx0;
    case (state_ff.serialRoute) // R20
      ROUTE_DIRECT: begin
        nxt_state.lnTx = directTxBit;
      end
      ROUTE_PROBE: begin
        own[LINE_T + 1:LINE_T]  = 2'h3;
        drv[LINE_T + 1:LINE_T]  = 2'h3;
        fdat[LINE_T + 1:LINE_T] = {serialTx0, transceiverRxd};
      end
      ROUTE_OPEN: begin
        own[LINE_S + 1:LINE_S]  = 2'h3; // R19
        drv[LINE_S + 1:LINE_S]  = 2'h2;
        fdat[LINE_S + 1]        = serialTx0;
        nxt_state.serRx0        = pinIn[LINE_S];
        nxt_state.lnTx          = 1'b1;
        // Transceiver off leaves T0 and T1 to other functions
        if (transceiverEnable) begin
          own[LINE_T + 1:LINE_T]  = 2'h3; // R19
          drv[LINE_T + 1:LINE_T]  = 2'h1;
          fdat[LINE_T]            = transceiverRxd;
          nxt_state.lnTx          = pinIn[LINE_T + 1];
        end
      end
      default: begin
        nxt_state.lnTx = serialTx0;
      end
    endcase

    // Timer channels take precedence; capture inputs follow the routed line
    for (int ch = 2; ch < 6; ch++) begin
      l                  = lineOf(FN_TMR0, ch, state_ff.timerRoute[ch]); // R5
      own[l]             = 1'b1;
      drv[l]             = tmr0Oe[ch];
      fdat[l]            = tmr0Out[ch];
      nxt_state.cap0[ch] = pinIn[l];
    end
    for (int ch = 0; ch < 2; ch++) begin
      l                  = lineOf(FN_TMR1, ch, state_ff.timerRoute[ch + 6]); // R4
      own[l]             = 1'b1;
      drv[l]             = tmr1Oe[ch];
      fdat[l]            = tmr1Out[ch];
      nxt_state.cap1[ch] = pinIn[l];
    end
    case (state_ff.capRoute) // R9
      CAP_AUX: nxt_state.cap0[3] = auxClock;
      CAP_RX1: nxt_state.cap0[3] = serialRx1;
      CAP_RX0: nxt_state.cap0[3] = nxt_state.serRx0;
      default: nxt_state.cap0[3] = pinIn[lineOf(FN_TMR0, 3, state_ff.timerRoute[3])];
    endcase

    // GPIO only where no function owns the line; input always reflects the pin
    nxt_state.pinOut     = (own & fdat) | (~own & gpioOut); // R17
    nxt_state.pinOe      = (own & drv) | (~own & gpioDir); // R17
    nxt_state.pinState   = pinIn; // R17
    // Pull stays off on push-pull drive whatever function owns the line
    nxt_state.pullActive = pullEnable & ~nxt_state.pinOe; // R16 R18

    // Interrupt pin; a new edge wins over a service clear in the same cycle
    nxt_state.irqPrev = irqPinN;
    fall              = state_ff.irqPrev & ~irqPinN;
    if (!state_ff.irqEdge) begin
      nxt_state.irqLatch = 1'b0;
    end else if (state_ff.irqConnect && fall) begin
      nxt_state.irqLatch = 1'b1; // R11
    end else if (irqServiced) begin
      nxt_state.irqLatch = 1'b0; // R11
    end
    nxt_state.irqReq = nxt_state.irqConnect & // R13
      (nxt_state.irqEdge ? nxt_state.irqLatch : ~irqPinN); // R11
  end

  // Single state register for all logic outside the reset and trigger submodules
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_ff         <= '0;
      state_ff.phase   <= BUS_IDLE;
      state_ff.irqPrev <= 1'b1;
      state_ff.lnTx    <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs; bus clock pin carries clk_sys, the enable alone is switched to avoid runts
  assign readdata       = {24'h000000, state_ff.rdata};
  assign pinOut         = state_ff.pinOut;
  assign pinOe          = state_ff.pinOe;
  assign pinState       = state_ff.pinState;
  assign pullActive     = state_ff.pullActive;
  assign tmr0CapIn      = state_ff.cap0;
  assign tmr1CapIn      = state_ff.cap1;
  assign serialRx0      = state_ff.serRx0;
  assign transceiverTxd = state_ff.lnTx;
  assign busClockOutPin = clk_sys;
  assign busClockOutOe  = ~state_ff.clkOutDisable; // R10
  assign irqRequest     = state_ff.irqReq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSyncN);

  lock_hold_a: assert property ( // R1
    wrTake && regIdx == IDX_PWM_ROUTE && state_ff.pwmLock && !specialMode
    |=> state_ff.pwmRoute == $past(state_ff.pwmRoute)) else $error("locked routing register changed");
  special_write_a: assert property ( // R1
    wrTake && regIdx == IDX_TIMER_ROUTE && specialMode
    |=> state_ff.timerRoute == ($past(writedata[7:0]) & MASK_TIMER)) else $error("special write lost");
  pwm_alt_a: assert property ( // R2
    state_ff.pwmRoute[5] |=> pinOut[LINE_J] == $past(pwmOut[5]) && pinOe[LINE_J]) else $error("pwm5 not on J0");
  timer_alt_a: assert property ( // R5
    state_ff.timerRoute[5] && tmr0Oe[5] |=> pinOut[LINE_S + 3] == $past(tmr0Out[5])) else $error("timer0 ch5 not on S3");
  clock_off_a: assert property ( // R10
    wrTake && regIdx == IDX_CLOCK_CTRL && writedata[CLK_DIS_BIT] |=> !busClockOutOe) else $error("clock output not off");
  irq_latch_a: assert property ( // R11
    state_ff.irqEdge && state_ff.irqConnect && state_ff.irqPrev && !irqPinN && !wrTake
    |=> irqRequest [*2]) else $error("falling edge not latched");
  irq_detach_a: assert property ( // R13
    !state_ff.irqConnect && !wrTake |=> !irqRequest) else $error("detached pin raised request");
  factory_guard_a: assert property ( // R14
    wrTake && regIdx == IDX_FACTORY_B && !specialMode |=> $stable(state_ff.factB)) else $error("factory write in normal mode");
  reserved_zero_a: assert property ( // R15
    read && !waitrequest && regIdx == IDX_PWM_ROUTE |-> readdata[3] == 1'b0 && readdata[1] == 1'b0)
    else $error("reserved bit read nonzero");
  answer_time_a: assert property ( // R21
    (read || write) && state_ff.phase == BUS_IDLE |=> !waitrequest) else $error("bus answer late");

endmodule : peripheral_signal_routing

// [verilog/reset_sync.sv]
// Purpose: Two-stage release of the asynchronous reset
// Assumes: rstn may fall at any time
// Notes:   Assertion is immediate, release follows two clock edges
module reset_sync (
  input  wire logic clk_sys,
  input  wire logic rstn,
  output logic      rstSyncN
);
  import routing_pkg::*;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_type;

  sync_type state_ff;
  sync_type nxt_state;

  // Stage two reads only stage one
  always_comb begin
    nxt_state.stage1 = 1'b1;
    nxt_state.stage2 = state_ff.stage1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rstSyncN = state_ff.stage2;

endmodule : reset_sync

// [verilog/routing_pkg.sv]
// Purpose: Shared constants and types for the peripheral signal routing block
// Assumes: Avalon-MM register word per index, byte address is four times the index
// Notes:   Lines are numbered P0-P7, T0-T7, S0-S3, J0-J1 in one flat vector
package routing_pkg;

  localparam int          ADDR_W    = 12;
  localparam int          DATA_W    = 32;
  localparam int          REG_W     = 8;
  localparam int          NUM_LINES = 22;

  // Register indices
  localparam logic [9:0]  IDX_SERIAL_ROUTE = 10'h200;
  localparam logic [9:0]  IDX_PWM_ROUTE    = 10'h201;
  localparam logic [9:0]  IDX_TIMER_ROUTE  = 10'h202;
  localparam logic [9:0]  IDX_TRIG_ROUTE   = 10'h203;
  localparam logic [9:0]  IDX_CAP_ROUTE    = 10'h204;
  localparam logic [9:0]  IDX_CLOCK_CTRL   = 10'h205;
  localparam logic [9:0]  IDX_IRQ_CTRL     = 10'h206;
  localparam logic [9:0]  IDX_FACTORY_A    = 10'h20D;
  localparam logic [9:0]  IDX_FACTORY_B    = 10'h20E;
  localparam logic [9:0]  IDX_FACTORY_C    = 10'h20F;

  // Implemented bits per register, all others read zero
  localparam logic [7:0]  MASK_SERIAL = 8'h07;
  localparam logic [7:0]  MASK_PWM    = 8'hF5;
  localparam logic [7:0]  MASK_TIMER  = 8'hFC;
  localparam logic [7:0]  MASK_TRIG   = 8'h0F;
  localparam logic [7:0]  MASK_CAP    = 8'h03;
  localparam logic [7:0]  MASK_CLOCK  = 8'h80;
  localparam logic [7:0]  MASK_IRQ    = 8'hC0;
  localparam logic [7:0]  RST_REG     = 8'h00;

  // Field positions
  localparam int          TRIG_CMP_BIT = 3;
  localparam int          TRIG_INV_BIT = 2;
  localparam int          CLK_DIS_BIT  = 7;
  localparam int          IRQ_EDGE_BIT = 7;
  localparam int          IRQ_CONN_BIT = 6;

  // Field encodings
  localparam logic [1:0]  TRIG_PIN_P6 = 2'h3;
  localparam logic [1:0]  TRIG_AD5    = 2'h2;
  localparam logic [1:0]  TRIG_PIN_E0 = 2'h1;
  localparam logic [1:0]  CAP_AUX     = 2'h3;
  localparam logic [1:0]  CAP_RX1     = 2'h2;
  localparam logic [1:0]  CAP_RX0     = 2'h1;
  localparam logic [2:0]  ROUTE_INTERNAL = 3'h0;
  localparam logic [2:0]  ROUTE_DIRECT   = 3'h1;
  localparam logic [2:0]  ROUTE_PROBE    = 3'h4;
  localparam logic [2:0]  ROUTE_OPEN     = 3'h6;

  // Line bases
  localparam int          LINE_P = 0;
  localparam int          LINE_T = 8;
  localparam int          LINE_S = 16;
  localparam int          LINE_J = 20;

  typedef enum {FN_PWM, FN_TMR0, FN_TMR1} func_type;
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_phase_type;

  // Package line that carries a channel for a given routing bit
  function automatic logic [4:0] lineOf(input func_type f, input int ch, input logic alt);
    int l;
    l = LINE_P + ch;
    case (f)
      FN_PWM: begin
        case (ch)
          7:       l = alt ? LINE_J + 1 : LINE_P + 7;
          6:       l = alt ? LINE_S + 1 : LINE_P + 6;
          5:       l = alt ? LINE_J + 0 : LINE_P + 5;
          4:       l = alt ? LINE_S + 0 : LINE_P + 4;
          2:       l = alt ? LINE_T + 0 : LINE_P + 2;
          default: l = alt ? LINE_T + 1 : LINE_P + 0;
        endcase
      end
      FN_TMR0: l = alt ? LINE_S + ch - 2 : LINE_T + ch;
      default: begin
        if (ch == 1) begin
          l = alt ? LINE_P + 1 : LINE_T + 7;
        end else begin
          l = alt ? LINE_P + 7 : LINE_T + 6;
        end
      end
    endcase
    return 5'(l);
  endfunction : lineOf

endpackage : routing_pkg

// [verilog/trigger_edge.sv]
// Purpose: Active-edge detector for the converter trigger
// Assumes: level is synchronous to clk_sys
// Notes:   Previous level resets high so a high source at reset gives no event
module trigger_edge (
  input  wire logic clk_sys,
  input  wire logic rstSyncN,
  input  wire logic level,
  input  wire logic invert,
  output logic      trigPulse
);
  import routing_pkg::*;

  typedef struct packed {
    logic prev;
    logic pulse;
  } edge_type;

  edge_type state_ff;
  edge_type nxt_state;
  logic     activeLevel;

  // Inversion ahead of the detector turns a falling edge into a rising one
  always_comb begin
    activeLevel     = level ^ invert; // R7 R23
    nxt_state.prev  = activeLevel;
    nxt_state.pulse = activeLevel & ~state_ff.prev; // R23
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_ff <= '{prev: 1'b1, pulse: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign trigPulse = state_ff.pulse;

  single_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstSyncN) // R23
    trigPulse |=> !trigPulse) else $error("trigger pulse lasted two cycles");
  edge_cause_a: assert property (@(posedge clk_sys) disable iff (!rstSyncN) // R7
    trigPulse |-> $past(activeLevel) && !$past(activeLevel, 2)) else $error("trigger pulse without edge");

endmodule : trigger_edge
